// ### hdl/pos_map.svh
// Register map, field positions, reset values and timing counts of the positioning block.
// Assumes it is included by its bare name from every design file that needs a constant.
//
// Function
// [R1] Without S-curve time constant, speed ramps linearly in acceleration and deceleration.
// [R2] With nonzero S-curve constant, ramp start and end are rounded for smooth motion.
// [R3] S-curve time constant accepts zero up to one thousand milliseconds.
// [R4] S-curve shaping delays positioning complete by the S-curve time constant.
// [R5] Alarm history keeps the present alarm and five earlier alarms since first power-up.
// [R6] Once history is erased, the clear setting returns to zero by itself.
// [R7] A written history clear acts only after power off and on again.
// [R8] Rough match rises once remaining command distance falls to the rough range.
// [R9] Rough range accepts 0 to 65535 in feed length units.
// [R10] Motion beyond the software limits stops the motor and holds it servo-locked.
// [R11] Software limits act from power-on and are suspended during home return.
// [R12] Software limits are off while positive and negative settings are equal.
// [R13] Positive limit below negative limit raises the parameter error alarm.
// [R14] Remaining distance is absolute target minus command position, updated each cycle.
`ifndef POS_MAP_SVH
`define POS_MAP_SVH

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 8
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define SCURVE_MAX_MS 10'h3E8
`define HIST_DEPTH 6

// ==========================================================================
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_TARGET 8'h04
`define OFF_SPEED 8'h08
`define OFF_ACCEL 8'h0C
`define OFF_SCURVE 8'h10
`define OFF_ROUGH 8'h14
`define OFF_LIM_POS 8'h18
`define OFF_LIM_NEG 8'h1C
`define OFF_HCLR 8'h20
`define OFF_STATUS 8'h24
`define OFF_IRQ_STAT 8'h28
`define OFF_IRQ_MASK 8'h2C
`define OFF_CMD_POS 8'h30
`define OFF_HIST 8'h34

// ==========================================================================
// Field positions
`define CTRL_START 0
`define CTRL_HOME 1
`define CTRL_EXP 2
`define EV_DONE 0
`define EV_ROUGH 1
`define EV_LIMIT 2
`define EV_PARAM 3
`define ST_BUSY 4

// ==========================================================================
// Reset values and codes
`define RST_SPEED 16'h0010
`define RST_ACCEL 16'h0001
`define ALARM_CODE_PARAM 8'h01

`endif

// ### hdl/pos_pkg.sv
// Types shared by the positioning block and its alarm history.
// Assumes nothing of its surroundings.
package pos_pkg;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_MOVE = 3'b010, S_DRAIN = 3'b100} move_state_t;
  typedef logic [7:0] alarm_code_t;
  typedef logic signed [31:0] position_t;

endpackage

// ### hdl/alarm_history.sv
// Alarm history of six entries with a clear setting that acts only at power-up.
// Assumes nv_resetn falls only at first power-up and hresetn at every power cycle.
`timescale 1ns/100ps
`include "pos_map.svh"
module alarm_history #(
  parameter int DEPTH = `HIST_DEPTH
) (
  // Clock and resets.
  input wire logic hclk,
  input wire logic nv_resetn,
  input wire logic hresetn,
  // Alarm source.
  input wire logic alarm_pulse,
  input wire pos_pkg::alarm_code_t alarm_code,
  // Clear setting.
  input wire logic clear_wr,
  input wire logic clear_val,
  output logic alarm_history_clear,
  output logic [DEPTH-1:0][7:0] entries
);
  import pos_pkg::*;

  // ==========================================================================
  // Power-up detection
  logic boot;
  wire erase = boot && alarm_history_clear;

  // The cycles under hresetn of a power cycle and the first cycle after it are the only moments a clear may act.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  // The clear setting survives power cycles and drops to zero after use.
  always_ff @(posedge hclk or negedge nv_resetn) begin
    if (!nv_resetn) begin
      alarm_history_clear <= 1'b0;
    end else if (clear_wr) begin
      alarm_history_clear <= clear_val;
    end else if (erase) begin
      alarm_history_clear <= 1'b0; // see [R6] see [R7]
    end
  end

  // ==========================================================================
  // History shift register, newest entry at index zero.
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge hclk or negedge nv_resetn) begin
        if (!nv_resetn) begin
          entries[i] <= 8'h00;
        end else if (erase) begin
          entries[i] <= 8'h00;
        end else if (alarm_pulse) begin
          entries[i] <= (i == 0) ? alarm_code : entries[(i == 0) ? 0 : i - 1]; // see [R5]
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Checks
  a_history_shift: assert property (@(posedge hclk) disable iff (!nv_resetn) // see [R5]
    alarm_pulse && !erase |=> entries[0] == $past(alarm_code) && entries[DEPTH-1] == $past(entries[DEPTH-2]))
    else $error("alarm history did not shift");
  a_clear_self: assert property (@(posedge hclk) disable iff (!nv_resetn) // see [R6]
    erase && !clear_wr |=> !alarm_history_clear && entries == '0)
    else $error("history clear did not erase and return to zero");
  a_clear_waits: assert property (@(posedge hclk) disable iff (!nv_resetn || !hresetn) // see [R7]
    !boot && !alarm_pulse |=> entries == $past(entries))
    else $error("history changed without an alarm or power cycle");
  c_history_erased: cover property (@(posedge hclk) disable iff (!nv_resetn) erase);

endmodule

// ### hdl/positioning_profile_and_limit_monitor.sv
// Positioning profile with S-curve shaping, rough match, software limits and alarm history.
// Assumes a single AHB-Lite master, hready driven from hreadyout, and one clock of 125 MHz.
`timescale 1ns/100ps
`include "pos_map.svh"
module positioning_profile_and_limit_monitor #(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int HIST_DEPTH = `HIST_DEPTH
) (
  // Clock and resets.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic nv_resetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Motion and status.
  output pos_pkg::position_t command_position,
  output logic positioning_complete_flag,
  output logic rough_match_flag,
  output logic parameter_error_alarm,
  output logic servo_lock,
  output logic irq
);
  import pos_pkg::*;

  // ==========================================================================
  // Declarations
  move_state_t state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic home_active;
  logic [1:0] feed_length_exponent;
  position_t target;
  logic [15:0] speed;
  logic [15:0] accel;
  logic [9:0] scurve_time_constant;
  logic [15:0] rough_match_range;
  position_t software_limit_positive_low;
  position_t software_limit_negative_high;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [31:0] ms_cnt;
  position_t lin_pos;
  logic dir;
  logic [15:0] vel;
  logic [31:0] dist_acc;
  logic [9:0] ts_lat;
  logic [9:0] fill;
  logic [9:0] idx;
  logic [9:0] drain_cnt;
  logic [25:0] sum;
  logic [15:0] vbuf [0:`SCURVE_MAX_MS-1];
  logic hist_clear;
  logic [HIST_DEPTH-1:0][7:0] hist;

  // Write decode of the pending data phase.
  function automatic logic wsel(input logic pend, input logic [7:0] a, input logic [7:0] off);
    return pend && (a == off);
  endfunction

  // ==========================================================================
  // Bus address phase and read mux
  wire addr_ok = hsel && hready && htrans[1];
  wire [7:0] ra = haddr[7:0];
  wire [7:0] hist_off = ra - `OFF_HIST;
  wire hist_hit = (ra >= `OFF_HIST) && (hist_off[7:2] < 6'(HIST_DEPTH)) && (hist_off[1:0] == 2'b00);
  wire [31:0] hist_word = {24'h00_0000, hist[3'(hist_off[7:2])]};
  wire [3:0] flags = {parameter_error_alarm, servo_lock, rough_match_flag, positioning_complete_flag};
  wire [31:0] rd_word =
    (ra == `OFF_CTRL) ? {28'h000_0000, feed_length_exponent, home_active, 1'b0} :
    (ra == `OFF_TARGET) ? target :
    (ra == `OFF_SPEED) ? {16'h0000, speed} :
    (ra == `OFF_ACCEL) ? {16'h0000, accel} :
    (ra == `OFF_SCURVE) ? {22'h00_0000, scurve_time_constant} :
    (ra == `OFF_ROUGH) ? {16'h0000, rough_match_range} :
    (ra == `OFF_LIM_POS) ? software_limit_positive_low :
    (ra == `OFF_LIM_NEG) ? software_limit_negative_high :
    (ra == `OFF_HCLR) ? {31'h0000_0000, hist_clear} :
    (ra == `OFF_STATUS) ? {27'h000_0000, state != S_IDLE, flags} :
    (ra == `OFF_IRQ_STAT) ? {28'h000_0000, irq_stat} :
    (ra == `OFF_IRQ_MASK) ? {28'h000_0000, irq_mask} :
    (ra == `OFF_CMD_POS) ? command_position :
    hist_hit ? hist_word : 32'h0000_0000;

  // Address phase capture; reads answer in the next cycle with no wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= ra;
      hrdata <= (addr_ok && !hwrite) ? rd_word : hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // Write strobes and settings
  wire start_wr = wsel(wr_pend, wr_addr, `OFF_CTRL) && hwdata[`CTRL_START];
  wire w1c_wr = wsel(wr_pend, wr_addr, `OFF_IRQ_STAT);
  wire [9:0] next_scurve = (hwdata > 32'(`SCURVE_MAX_MS)) ? `SCURVE_MAX_MS : hwdata[9:0];

  // Settings written by software; the S-curve constant saturates at its maximum.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      home_active <= 1'b0;
      feed_length_exponent <= 2'h0;
      target <= 32'h0000_0000;
      speed <= `RST_SPEED;
      accel <= `RST_ACCEL;
      scurve_time_constant <= 10'h000;
      rough_match_range <= 16'h0000;
      software_limit_positive_low <= 32'h0000_0000;
      software_limit_negative_high <= 32'h0000_0000;
      irq_mask <= 4'h0;
    end else begin
      if (wsel(wr_pend, wr_addr, `OFF_CTRL)) begin
        home_active <= hwdata[`CTRL_HOME];
        feed_length_exponent <= hwdata[`CTRL_EXP+1:`CTRL_EXP];
      end
      if (wsel(wr_pend, wr_addr, `OFF_TARGET)) target <= hwdata;
      if (wsel(wr_pend, wr_addr, `OFF_SPEED)) speed <= hwdata[15:0];
      if (wsel(wr_pend, wr_addr, `OFF_ACCEL)) accel <= hwdata[15:0];
      if (wsel(wr_pend, wr_addr, `OFF_SCURVE)) scurve_time_constant <= next_scurve; // see [R3]
      if (wsel(wr_pend, wr_addr, `OFF_ROUGH)) rough_match_range <= hwdata[15:0]; // see [R9]
      if (wsel(wr_pend, wr_addr, `OFF_LIM_POS)) software_limit_positive_low <= hwdata;
      if (wsel(wr_pend, wr_addr, `OFF_LIM_NEG)) software_limit_negative_high <= hwdata;
      if (wsel(wr_pend, wr_addr, `OFF_IRQ_MASK)) irq_mask <= hwdata[3:0];
    end
  end

  // ==========================================================================
  // Control tick of one millisecond
  wire tick = (ms_cnt == 32'(MS_CYCLES - 1));

  // Free running millisecond divider.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= 32'h0000_0000;
    end else begin
      ms_cnt <= tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Linear profile generator
  wire signed [32:0] lin_diff = {target[31], target} - {lin_pos[31], lin_pos};
  wire [32:0] lin_neg = -lin_diff;
  wire [31:0] lin_rem = lin_diff[32] ? lin_neg[31:0] : lin_diff[31:0];
  wire decel = dist_acc >= lin_rem;
  wire [16:0] v_up = {1'b0, vel} + {1'b0, accel};
  wire [15:0] v_acc = (v_up > {1'b0, speed}) ? speed : v_up[15:0];
  wire [15:0] v_dec = (vel > accel) ? vel - accel : 16'h0001;
  wire [15:0] v_next = decel ? v_dec : v_acc; // see [R1]
  wire [15:0] step = ({16'h0000, v_next} > lin_rem) ? lin_rem[15:0] : v_next;
  wire signed [31:0] lin_next = dir ? lin_pos - 32'(step) : lin_pos + 32'(step);
  wire [31:0] next_dist = decel ? ((dist_acc > 32'(step)) ? dist_acc - 32'(step) : 32'h0000_0000)
                                : dist_acc + 32'(v_next - vel);

  // ==========================================================================
  // Software limits and parameter error
  wire param_bad = software_limit_positive_low < software_limit_negative_high; // see [R13]
  wire limit_en = !home_active && (software_limit_positive_low != software_limit_negative_high)
                  && !param_bad; // see [R11] see [R12]
  wire limit_hit = (state == S_MOVE) && limit_en && (lin_next > software_limit_positive_low
                   || lin_next < software_limit_negative_high); // see [R10]

  // ==========================================================================
  // S-curve moving average over the latched time constant in milliseconds
  wire [15:0] f_in = (state == S_MOVE) ? step : 16'h0000;
  wire [15:0] f_old = (fill == ts_lat && ts_lat != 10'h000) ? vbuf[idx] : 16'h0000;
  wire [25:0] f_sum = sum + 26'(f_in) - 26'(f_old);
  wire [25:0] f_quot = f_sum / 26'(ts_lat);
  wire [15:0] f_out = (ts_lat == 10'h000) ? f_in : f_quot[15:0]; // see [R1] see [R2]
  wire signed [31:0] cmd_next = dir ? command_position - 32'(f_out) : command_position + 32'(f_out);
  wire drain_done = (state == S_DRAIN) && (drain_cnt == ts_lat); // see [R4]
  wire ts_wrap = (idx == ts_lat - 10'h001);

  // Speed history of the filter; only the first ts_lat words are used.
  always_ff @(posedge hclk) begin
    if (tick && state != S_IDLE && ts_lat != 10'h000) vbuf[idx] <= f_in;
  end

  // ==========================================================================
  // Remaining distance and rough match
  wire signed [32:0] cmd_diff = {target[31], target} - {command_position[31], command_position};
  wire [32:0] cmd_neg = -cmd_diff;
  wire [31:0] cmd_rem = cmd_diff[32] ? cmd_neg[31:0] : cmd_diff[31:0]; // see [R14]
  wire rough_now = (state != S_IDLE) && (cmd_rem <= {16'h0000, rough_match_range}); // see [R8]
  wire start_ok = start_wr && (state == S_IDLE) && !param_bad;

  // ==========================================================================
  // Move sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      command_position <= 32'h0000_0000;
      lin_pos <= 32'h0000_0000;
      dir <= 1'b0;
      vel <= 16'h0000;
      dist_acc <= 32'h0000_0000;
      ts_lat <= 10'h000;
      fill <= 10'h000;
      idx <= 10'h000;
      drain_cnt <= 10'h000;
      sum <= 26'h000_0000;
    end else if (start_ok) begin
      state <= S_MOVE;
      lin_pos <= command_position;
      dir <= target < command_position;
      vel <= 16'h0000;
      dist_acc <= 32'h0000_0000;
      ts_lat <= scurve_time_constant;
      fill <= 10'h000;
      idx <= 10'h000;
      drain_cnt <= 10'h000;
      sum <= 26'h000_0000;
    end else if (tick) begin
      unique case (state)
        S_IDLE: begin
        end
        S_MOVE: begin
          if (limit_hit) begin
            state <= S_IDLE; // see [R10]
            vel <= 16'h0000;
          end else begin
            state <= (lin_rem == 32'(step)) ? S_DRAIN : S_MOVE;
            lin_pos <= lin_next;
            vel <= v_next;
            dist_acc <= next_dist;
          end
        end
        S_DRAIN: begin
          drain_cnt <= drain_cnt + 10'h001;
          state <= drain_done ? S_IDLE : S_DRAIN;
        end
      endcase
      if (state != S_IDLE && !limit_hit) begin
        command_position <= drain_done ? target : cmd_next;
        sum <= f_sum;
        idx <= ts_wrap ? 10'h000 : idx + 10'h001;
        fill <= (fill == ts_lat) ? fill : fill + 10'h001;
      end
    end
  end

  // ==========================================================================
  // Status flags, events and interrupt
  wire [3:0] events = {param_bad && !parameter_error_alarm, tick && limit_hit,
                       rough_now && !rough_match_flag, tick && drain_done};

  // Complete, rough and lock flags hold until the next accepted start, a set beating a same-cycle clear; the alarm follows param_bad.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      positioning_complete_flag <= 1'b0;
      rough_match_flag <= 1'b0;
      servo_lock <= 1'b0;
      parameter_error_alarm <= 1'b0;
      irq_stat <= 4'h0;
      irq <= 1'b0;
    end else begin
      positioning_complete_flag <= (positioning_complete_flag && !start_ok) || (tick && drain_done);
      rough_match_flag <= (rough_match_flag && !start_ok) || rough_now; // see [R8]
      servo_lock <= (servo_lock && !start_ok) || (tick && limit_hit); // see [R10]
      parameter_error_alarm <= param_bad; // see [R13]
      irq_stat <= (irq_stat & ~(w1c_wr ? hwdata[3:0] : 4'h0)) | events;
      irq <= |(((irq_stat & ~(w1c_wr ? hwdata[3:0] : 4'h0)) | events) & irq_mask);
    end
  end

  // ==========================================================================
  // Alarm history
  alarm_history #(.DEPTH(HIST_DEPTH)) u_history (
    .hclk(hclk),
    .nv_resetn(nv_resetn),
    .hresetn(hresetn),
    .alarm_pulse(events[`EV_PARAM]),
    .alarm_code(`ALARM_CODE_PARAM),
    .clear_wr(wsel(wr_pend, wr_addr, `OFF_HCLR)),
    .clear_val(hwdata[0]),
    .alarm_history_clear(hist_clear),
    .entries(hist)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_linear_track: assert property (state == S_MOVE && ts_lat == 10'h000 |-> command_position == lin_pos) // see [R1]
    else $error("linear profile does not track the ramp");
  a_scurve_round: assert property (tick && state == S_MOVE && ts_lat > 10'h001 && fill == 10'h000 // see [R2]
    && f_in != 16'h0000 |-> f_out < f_in)
    else $error("S-curve start was not rounded");
  a_scurve_range: assert property (scurve_time_constant <= `SCURVE_MAX_MS) // see [R3]
    else $error("S-curve constant above its maximum");
  a_complete_delay: assert property ($rose(positioning_complete_flag) |-> $past(drain_cnt) == ts_lat) // see [R4]
    else $error("completion not delayed by the S-curve constant");
  a_rough_set: assert property (rough_now && !start_ok |=> rough_match_flag) // see [R8]
    else $error("rough match not raised");
  a_limit_stop: assert property (tick && limit_hit && !start_ok // see [R10]
    |=> servo_lock && state == S_IDLE && command_position == $past(command_position))
    else $error("limit did not stop and lock");
  a_limit_off: assert property (home_active || software_limit_positive_low == software_limit_negative_high // see [R11]
    |-> !limit_hit)
    else $error("limit acted while suspended");
  a_param_error: assert property (param_bad && !parameter_error_alarm // see [R13]
    |=> parameter_error_alarm && hist[0] == `ALARM_CODE_PARAM)
    else $error("parameter error not raised or not recorded");
  c_scurve_done: cover property ($rose(positioning_complete_flag) && ts_lat != 10'h000);
  c_limit_stop: cover property ($rose(servo_lock));
  c_rough_then_done: cover property ($rose(rough_match_flag) ##[1:1000] $rose(positioning_complete_flag));

endmodule

// ### bench/pos_master.sv
// AHB-Lite master model that stands in for the fieldbus controller issuing positioning commands.
// Assumes one slave whose hreadyout is hready, and callers that start a transfer just after a rising edge.
`timescale 1ns/100ps
module pos_master (
  // Clock and handshake.
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request signals.
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ==========================================================================
  // Transfers
  // The bus is idle at time zero.
  initial begin
    hsel = 1'h0;
    haddr = 32'hFFFF_FFFF;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // One single word transfer: each phase holds until hready is sampled high.
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    rd = hrdata;
    // Released data lines must not keep showing the written word.
    hwdata <= ~wd;
  endtask
endmodule

// ### bench/positioning_profile_and_limit_monitor_tb.sv
// Self-checking testbench of the positioning block, driven over AHB-Lite.
// Assumes pos_map.svh on the include path and a short millisecond tick of four clocks.
`timescale 1ns/100ps
`include "pos_map.svh"
module positioning_profile_and_limit_monitor_tb;
  import pos_pkg::*;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic nv_resetn = 1'h0;
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic positioning_complete_flag, rough_match_flag, parameter_error_alarm, servo_lock, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  position_t command_position;
  int miscompares = 0;
  int compares = 0;
  int n0, n1, rdist;

  // ==========================================================================
  // Instances
  // The only slave's ready is the bus ready.
  assign hready = hreadyout;
  pos_master master (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  positioning_profile_and_limit_monitor #(.MS_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn),
    .nv_resetn(nv_resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .command_position(command_position), .positioning_complete_flag(positioning_complete_flag),
    .rough_match_flag(rough_match_flag), .parameter_error_alarm(parameter_error_alarm),
    .servo_lock(servo_lock), .irq(irq));

  // The clock toggles every half period of 4 ns.
  always #4 hclk = ~hclk;

  // ==========================================================================
  // Helpers
  // Compares one value and reports a mismatch at once.
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    master.xfer(a, 1'h1, v, d);
  endtask

  task rd(input logic [7:0] a);
    master.xfer(a, 1'h0, 32'h0000_0000, d);
  endtask

  // Starts a move and counts cycles until it completes or is stopped by a limit.
  task move(input logic [31:0] tgt, input logic [31:0] ctrl, output int n);
    wr(`OFF_TARGET, tgt);
    wr(`OFF_CTRL, ctrl);
    repeat (2) @(posedge hclk);
    n = 0;
    rdist = -1;
    while (positioning_complete_flag !== 1'h1 && servo_lock !== 1'h1 && n < 3000) begin
      if (rough_match_flag === 1'h1 && rdist < 0) rdist = tgt - command_position;
      @(posedge hclk);
      n++;
    end
    check("move ends", n < 3000, 1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // Reset values, an unmapped place and the response code.
  task t_reset;
    rd(`OFF_SPEED);
    check("speed", d, 32'h0000_0010);
    rd(`OFF_SCURVE);
    check("scurve", d, 32'h0000_0000);
    wr(8'h50, 32'hFFFF_FFFF);
    rd(8'h50);
    check("unmapped", d, 32'h0000_0000);
    check("hresp", hresp, 1'h0);
  endtask

  // Crossed limits raise the alarm, its interrupt is masked, unmasked and cleared.
  task t_param;
    wr(`OFF_LIM_POS, 32'h0000_0005);
    wr(`OFF_LIM_NEG, 32'h0000_000A);
    repeat (2) @(posedge hclk);
    check("param alarm", parameter_error_alarm, 1'h1);
    check("irq masked", irq, 1'h0);
    rd(`OFF_IRQ_STAT);
    check("irq stat", d & 32'h0000_0008, 32'h0000_0008);
    wr(`OFF_IRQ_MASK, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    check("irq on", irq, 1'h1);
    wr(`OFF_IRQ_STAT, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    check("irq off", irq, 1'h0);
    rd(`OFF_HIST);
    check("history", d[7:0], 8'h01);
    wr(`OFF_LIM_NEG, 32'h0000_0000);
    wr(`OFF_LIM_POS, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    check("alarm gone", parameter_error_alarm, 1'h0);
  endtask

  // Linear move with rough match, then a mirrored S-curve move that ends later.
  task t_profile;
    wr(`OFF_ACCEL, 32'h0000_0004);
    wr(`OFF_SPEED, 32'h0000_0008);
    wr(`OFF_ROUGH, 32'h0000_000A);
    move(32'h0000_0028, 32'h0000_0001, n0);
    check("linear end", command_position, 32'h0000_0028);
    check("rough flag", rough_match_flag, 1'h1);
    check("rough dist", rdist >= 0 && rdist <= 10, 1);
    wr(`OFF_SCURVE, 32'h0000_07D0);
    rd(`OFF_SCURVE);
    check("scurve max", d, 32'h0000_03E8);
    wr(`OFF_SCURVE, 32'h0000_0003);
    move(32'h0000_0000, 32'h0000_0001, n1);
    check("scurve end", command_position, 32'h0000_0000);
    check("scurve delay", n1 - n0 >= 8 && n1 - n0 <= 16, 1);
    wr(`OFF_SCURVE, 32'h0000_0000);
  endtask

  // Limit stop, suspension during home return, and limits off when equal.
  task t_limit;
    wr(`OFF_LIM_POS, 32'h0000_0014);
    wr(`OFF_LIM_NEG, 32'hFFFF_FFEC);
    move(32'h0000_0064, 32'h0000_0001, n1);
    check("servo lock", servo_lock, 1'h1);
    check("held inside", command_position <= 20, 1);
    rd(`OFF_STATUS);
    check("status", d, 32'h0000_0004);
    move(32'h0000_0064, 32'h0000_0003, n1);
    check("home pass", command_position, 32'h0000_0064);
    wr(`OFF_LIM_POS, 32'h0000_0000);
    wr(`OFF_LIM_NEG, 32'h0000_0000);
    move(32'h0000_012C, 32'h0000_0001, n1);
    check("limits off", command_position, 32'h0000_012C);
    check("no lock", servo_lock, 1'h0);
  endtask

  // History clear waits for a power cycle, then erases and returns to zero.
  task t_hist;
    wr(`OFF_HCLR, 32'h0000_0001);
    rd(`OFF_HCLR);
    check("clear kept", d, 32'h0000_0001);
    rd(`OFF_HIST);
    check("not erased", d[7:0], 8'h01);
    hresetn <= 1'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(`OFF_HCLR);
    check("clear back", d, 32'h0000_0000);
    rd(`OFF_HIST);
    check("erased", d[7:0], 8'h00);
  endtask

  // ==========================================================================
  // Sequence
  // Power-up reset for six cycles, then every scenario in turn.
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    nv_resetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_param();
    t_profile();
    t_limit();
    t_hist();
    finish_test();
  end

  // A hang is cut short well beyond the few hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    finish_test();
  end
endmodule
